// ===== src/spmp_port.sv
// What this block does
// - Each byte sent is exchanged with the incoming byte in one shift register.
// - Only the master starts transfers, by a data write; slaves never drive clock.
// - Data writes load the shift register directly; in master mode shifting starts at once.
// - Transfer ends after eight serial clocks and sets transfer complete.
// - At completion the received byte is copied to the receive buffer.
// - Slave shifts on the external clock and buffers each complete byte.
// - Master drives clock and master-out, samples master-in.
// - Low slave select in master mode disables, drops master, sets fault.
// - Slave takes clock in, receives on master-out, drives master-in.
// - Slave works only while slave select is low.
// - Phase zero slave shifts on clock edges while select is low, as in phase one.
// - A data write while an enabled phase-zero slave is selected always flags a collision.
// - Reset leaves idle level at zero and phase at one.
// - All ports share the lines; exactly one is master.
// - Master offers four clock rates, the highest 1.05 MHz.
// - Slave works with an external clock up to 2.1 MHz.
// - Rate bits divide by 2, 4, 16 or 32; ignored in slave mode.
// - Idle level bit sets the clock level between transfers.
// - Phase zero latches on first edge, phase one on the second.
// - Data write during a transfer sets collision and is dropped.
`default_nettype none

module spmp_port
    import spmp_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        sck_i,
    input  wire logic        mosi_i,
    input  wire logic        miso_i,
    input  wire logic        ss_n_i,
    output spmp_pins_out_t   pins,
    output logic             irq
);
    // ==========================================================
    // State.
    typedef struct packed {
        logic        irq_en;
        logic        enable;
        logic        master;
        logic        idle_lvl;
        logic        phase;
        logic [1:0]  rate;
        logic        complete;
        logic        collision;
        logic        fault;
        logic        sts_armed;
        logic [7:0]  shift;
        logic [7:0]  rx_buf;
        logic        in_bit;
        logic [3:0]  count;
        logic [15:0] div;
        spmp_phase_t ph;
        logic        d_pend;
        logic        d_write;
        logic [9:0]  d_addr;
        logic [31:0] rdata;
        spmp_pins_out_t pins;
        logic        irq;
    } spmp_state_t;

    spmp_state_t st;
    spmp_state_t next_st;

    logic       sck_s;
    logic       ss_s;
    logic [2:0] rise_s;
    logic [2:0] fall_s;
    logic [2:0] lvl_s;

    // The clock and select levels are resynchronised; the slave clock must stay well below
    // hclk, which holds by a wide margin at 2.1 MHz.
    spmp_edge #(.WIDTH(3)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .raw     ({sck_i, ss_n_i, 1'b0}),
        .level   (lvl_s),
        .rise    (rise_s),
        .fall    (fall_s)
    );

    assign sck_s = lvl_s[2];
    assign ss_s  = lvl_s[1];

    function automatic logic [15:0] half_period(input logic [1:0] code);
        unique case (code)
            2'b00: half_period = SPMP_HALF_00;
            2'b01: half_period = SPMP_HALF_01;
            2'b10: half_period = SPMP_HALF_10;
            2'b11: half_period = SPMP_HALF_11;
        endcase
    endfunction

    logic       ap_take;
    logic       busy;
    logic       serial_in;
    logic       lead_edge;
    logic       trail_edge;
    logic       slave_clk;
    logic       sclk_prev;
    logic       s_rise;
    logic       s_fall;
    logic [7:0] wbyte;

    assign ap_take = hsel && hready && htrans[1];
    assign wbyte   = hwdata[7:0];

    always_comb begin
        next_st   = st;
        busy      = (st.ph != SPMP_IDLE);
        serial_in = st.master ? miso_i : mosi_i;
        lead_edge  = 1'b0;
        trail_edge = 1'b0;
        // select ORed with clock for phase zero; the slave edge logic does not use it.
        slave_clk  = st.phase ? sck_s : (ss_s | sck_s);
        sclk_prev  = slave_clk;
        s_rise = 1'b0;
        s_fall = 1'b0;
        if (st.phase) begin
            s_rise = rise_s[2] && !ss_s;
            s_fall = fall_s[2] && !ss_s;
        end else begin
            s_rise = rise_s[2] && !ss_s;
            s_fall = fall_s[2] && !ss_s;
        end

        // ======================================================
        // Bus data phase.
        next_st.d_pend = 1'b0;
        if (st.d_pend && st.d_write) begin
            if (st.d_addr == SPMP_ADDR_CONTROL) begin
                next_st.irq_en   = wbyte[SPMP_CTL_IRQ_EN];
                next_st.enable   = wbyte[SPMP_CTL_ENABLE];
                next_st.master   = wbyte[SPMP_CTL_MASTER];
                next_st.idle_lvl = wbyte[SPMP_CTL_IDLE_LVL];
                next_st.phase    = wbyte[SPMP_CTL_PHASE];
                next_st.rate     = wbyte[SPMP_CTL_RATE_HI:SPMP_CTL_RATE_LO];
                if (st.sts_armed) begin
                    next_st.fault = 1'b0;
                end
            end else if (st.d_addr == SPMP_ADDR_DATA) begin
                if (st.sts_armed) begin
                    next_st.complete  = 1'b0;
                    next_st.collision = 1'b0;
                end
                // enabled slave with phase zero collides whenever selected.
                if (busy || (!st.master && !st.phase && !ss_s && st.enable)) begin
                    next_st.collision = 1'b1;
                end else begin
                    next_st.shift = wbyte;
                    if (st.master && st.enable) begin
                        next_st.ph    = SPMP_LEAD;
                        next_st.count = '0;
                        next_st.div   = half_period(st.rate);
                    end
                end
            end
        end else if (st.d_pend && st.d_addr == SPMP_ADDR_DATA && st.sts_armed) begin
            next_st.complete  = 1'b0;
            next_st.collision = 1'b0;
        end
        if (st.d_pend && st.d_addr == SPMP_ADDR_STATUS && !st.d_write) begin
            next_st.sts_armed = st.complete | st.collision | st.fault;
        end else if (st.d_pend && st.d_addr != SPMP_ADDR_STATUS) begin
            next_st.sts_armed = 1'b0;
        end

        // ======================================================
        // Master and slave serial engines.
        if (st.master && st.enable && busy) begin
            if (st.div > 16'd1) begin
                next_st.div = st.div - 16'd1;
            end else begin
                next_st.div = half_period(st.rate);
                if (st.ph == SPMP_LEAD) begin
                    lead_edge  = 1'b1;
                    next_st.ph = SPMP_TRAIL;
                end else begin
                    trail_edge = 1'b1;
                    next_st.ph = SPMP_LEAD;
                end
            end
        end else if (!st.master && st.enable && !ss_s) begin
            lead_edge  = st.idle_lvl ? s_fall : s_rise;
            trail_edge = st.idle_lvl ? s_rise : s_fall;
            if (lead_edge && st.ph == SPMP_IDLE) begin
                next_st.ph = SPMP_LEAD;
            end
        end

        // each sampled bit but the eighth of phase one (taken from the line into rx_buf) waits in in_bit and enters the shift register on the
        // next output edge, so the outgoing line never moves at a sampling edge.
        if (st.phase ? trail_edge : lead_edge) begin
            next_st.in_bit = serial_in;
        end
        if (st.phase ? (lead_edge && st.count != 4'd0) : trail_edge) begin
            next_st.shift = {st.shift[6:0], st.in_bit};
        end
        if (trail_edge) begin
            next_st.count = st.count + 4'd1;
            if (st.count + 4'd1 == SPMP_BITS) begin
                next_st.ph       = SPMP_IDLE;
                next_st.count    = '0;
                next_st.complete = 1'b1;
                next_st.rx_buf   = st.phase ? {st.shift[6:0], serial_in}
                                            : {st.shift[6:0], st.in_bit};
            end
        end
        // A slave whose select rises mid-byte, in either phase, drops the byte.
        if (!st.master && ss_s && busy) begin
            next_st.ph    = SPMP_IDLE;
            next_st.count = '0;
        end

        // ======================================================
        // Mode fault.
        if (st.master && !ss_s) begin
            next_st.master = 1'b0;
            next_st.enable = 1'b0;
            next_st.fault  = 1'b1;
            next_st.ph     = SPMP_IDLE;
            next_st.count  = '0;
        end

        // ======================================================
        // Pins.
        next_st.pins.sck_oe  = next_st.master && next_st.enable;
        next_st.pins.mosi_oe = next_st.master && next_st.enable;
        next_st.pins.miso_oe = !next_st.master && next_st.enable && !ss_s;
        next_st.pins.sck_o   = next_st.idle_lvl ^ (next_st.ph == SPMP_TRAIL);
        // Phase zero puts the top bit out before the first edge.
        next_st.pins.mosi_o  = next_st.shift[7];
        next_st.pins.miso_o  = next_st.shift[7];
        next_st.irq = next_st.irq_en && (next_st.complete || next_st.fault);

        // ======================================================
        // Bus address phase and read data.
        if (ap_take) begin
            next_st.d_pend  = 1'b1;
            next_st.d_write = hwrite;
            next_st.d_addr  = haddr[9:0];
            next_st.rdata   = '0;
            if (haddr[9:0] == SPMP_ADDR_CONTROL) begin
                next_st.rdata[7:0] = {st.irq_en, st.enable, 1'b0, st.master,
                                      st.idle_lvl, st.phase, st.rate};
            end else if (haddr[9:0] == SPMP_ADDR_STATUS) begin
                next_st.rdata[SPMP_STS_COMPLETE]  = st.complete;
                next_st.rdata[SPMP_STS_COLLISION] = st.collision;
                next_st.rdata[SPMP_STS_FAULT]     = st.fault;
            end else if (haddr[9:0] == SPMP_ADDR_DATA) begin
                next_st.rdata[7:0] = next_st.rx_buf;
            end
        end
        if (sclk_prev) begin
            next_st.in_bit = next_st.in_bit;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st          <= '0;
            st.idle_lvl <= SPMP_RST_IDLE_LVL;
            st.phase    <= SPMP_RST_PHASE;
            st.rate     <= SPMP_RST_RATE;
            st.shift    <= SPMP_RST_DATA;
            st.rx_buf   <= SPMP_RST_DATA;
            st.ph       <= SPMP_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // Registered bus answer: zero wait states, always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    assign hrdata = st.rdata;
    assign hresp  = 1'b0;
    assign pins   = st.pins;
    assign irq    = st.irq;
endmodule

`default_nettype wire

// ===== src/spmp_pkg.sv
`default_nettype none

package spmp_pkg;

    // ==========================================================
    // Register map: printed offsets are not word multiples, so they are
    // indices and the byte address is four times the index.
    localparam logic [7:0] SPMP_IDX_CONTROL = 8'h0a;
    localparam logic [7:0] SPMP_IDX_STATUS  = 8'h0b;
    localparam logic [7:0] SPMP_IDX_DATA    = 8'h0c;
    localparam logic [9:0] SPMP_ADDR_CONTROL = {SPMP_IDX_CONTROL, 2'b00};
    localparam logic [9:0] SPMP_ADDR_STATUS  = {SPMP_IDX_STATUS, 2'b00};
    localparam logic [9:0] SPMP_ADDR_DATA    = {SPMP_IDX_DATA, 2'b00};

    // ==========================================================
    // Control register fields.
    localparam int SPMP_CTL_IRQ_EN   = 7;
    localparam int SPMP_CTL_ENABLE   = 6;
    localparam int SPMP_CTL_MASTER   = 4;
    localparam int SPMP_CTL_IDLE_LVL = 3;
    localparam int SPMP_CTL_PHASE    = 2;
    localparam int SPMP_CTL_RATE_HI  = 1;
    localparam int SPMP_CTL_RATE_LO  = 0;
    localparam logic [7:0] SPMP_CTL_IMPL_MASK = 8'hdf;

    // ==========================================================
    // Status register fields.
    localparam int SPMP_STS_COMPLETE  = 7;
    localparam int SPMP_STS_COLLISION = 6;
    localparam int SPMP_STS_FAULT     = 4;

    // ==========================================================
    // Values after reset.
    localparam logic       SPMP_RST_IDLE_LVL = 1'b0;
    localparam logic       SPMP_RST_PHASE    = 1'b1;
    localparam logic [1:0] SPMP_RST_RATE     = 2'b00;
    localparam logic [7:0] SPMP_RST_DATA     = 8'h00;

    // ==========================================================
    // Timing: half periods of the master clock per rate code, in hclk.
    localparam int    SPMP_HCLK_MHZ  = 250;
    localparam real   SPMP_MASTER_MAX_MHZ = 1.05;
    localparam real   SPMP_SLAVE_MAX_MHZ  = 2.1;
    // Internal clock is taken as twice the top master rate.
    localparam int    SPMP_INT_DIV =
        int'($floor(real'(SPMP_HCLK_MHZ) / (2.0 * SPMP_MASTER_MAX_MHZ)));
    localparam logic [15:0] SPMP_HALF_00 = 16'(SPMP_INT_DIV * 2 / 2);
    localparam logic [15:0] SPMP_HALF_01 = 16'(SPMP_INT_DIV * 4 / 2);
    localparam logic [15:0] SPMP_HALF_10 = 16'(SPMP_INT_DIV * 16 / 2);
    localparam logic [15:0] SPMP_HALF_11 = 16'(SPMP_INT_DIV * 32 / 2);
    localparam logic [3:0]  SPMP_BITS    = 4'h8;

    typedef enum logic [1:0] {
        SPMP_IDLE,
        SPMP_LEAD,
        SPMP_TRAIL
    } spmp_phase_t;

    // Pins that belong together.
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic mosi_o;
        logic mosi_oe;
        logic miso_o;
        logic miso_oe;
    } spmp_pins_out_t;

endpackage

`default_nettype wire

// ===== src/spmp_edge.sv
`default_nettype none

// Two-stage synchroniser with a combinational edge report on the second stage.
module spmp_edge
    import spmp_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } spmp_sync_t;

    spmp_sync_t st;
    spmp_sync_t next_st;

    always_comb begin
        next_st      = st;
        next_st.meta = raw;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '1;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.sync;
    assign rise  = st.sync & ~st.prev;
    assign fall  = ~st.sync & st.prev;
endmodule

`default_nettype wire

// ===== bench/spmp_asserts.sv
`default_nettype none

module spmp_asserts
    import spmp_pkg::*;
(
    input wire logic           hclk,
    input wire logic           hresetn,
    input wire logic           hsel,
    input wire logic [31:0]    haddr,
    input wire logic [1:0]     htrans,
    input wire logic           hwrite,
    input wire logic           hready,
    input wire logic [31:0]    hrdata,
    input wire logic           hreadyout,
    input wire logic           hresp,
    input wire logic           ss_n_i,
    input wire spmp_pins_out_t pins
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ==========
    // Helper logic
    logic unmapped_rd;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) unmapped_rd <= 1'b0;
        else unmapped_rd <= hsel && hready && htrans[1] && !hwrite
            && !(haddr[9:0] inside {SPMP_ADDR_CONTROL, SPMP_ADDR_STATUS, SPMP_ADDR_DATA});
    end

    sequence s_contention;
        pins.sck_oe && !ss_n_i;
    endsequence
    sequence s_released;
        ##[1:8] !pins.sck_oe;
    endsequence
    sequence s_clock_edge;
        pins.sck_oe && $changed(pins.sck_o);
    endsequence

    // ==========
    // Checks
    a_fault_release: assert property (s_contention |-> s_released)
        else $error("master kept driving the clock with select low");
    a_oe_exclusive: assert property (!(pins.sck_oe && pins.miso_oe))
        else $error("clock and slave output driven together");
    a_pins_paired: assert property (pins.sck_oe == pins.mosi_oe)
        else $error("clock and master output enables differ");
    // The shortest legal half period is far above eight cycles.
    a_half_period: assert property (s_clock_edge |=> $stable(pins.sck_o)[*8])
        else $error("serial clock half period too short");
    a_ready_high: assert property ($past(hresetn) |-> hreadyout)
        else $error("bus wait state inserted");
    a_rdata_byte: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("read data wider than a byte");
    a_unmapped_zero: assert property (unmapped_rd |-> hrdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_resp_okay: assert property (!hresp)
        else $error("error response seen");
endmodule

`default_nettype wire

// ===== bench/spmp_far_slave.sv
`default_nettype none

module spmp_far_slave (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    input  wire logic       clock_idle_level,
    input  wire logic       clock_phase_bit,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] shift = 8'h00;
    logic       out_bit = 1'b0;
    assign miso = out_bit;
    assign rx_byte = shift;
    // A released line shows the inverse so a stale bit never passes as valid.
    always @(posedge sel_n) out_bit = ~out_bit;
    always @(negedge sel_n) begin
        shift = tx_byte;
        if (!clock_phase_bit) out_bit = shift[7];
    end
    always @(sck) begin
        if (!sel_n) begin
            if ((sck ^ clock_idle_level) == clock_phase_bit) out_bit = shift[7];
            else shift = {shift[6:0], mosi};
        end
    end
endmodule

`default_nettype wire

// ===== bench/tb_top.sv
`default_nettype none

module tb_top
    import spmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, irq;
    spmp_pins_out_t pins;
    logic        ss_n = 1'b1, far_sel_n = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0;
    logic        far_clock_idle_level = 1'b0, far_clock_phase_bit = 1'b1, sck_q = 1'b0;
    logic [7:0]  far_tx = 8'h00;
    wire logic [7:0] far_rx;
    wire logic   far_miso;
    wire logic   sck_w = pins.sck_oe ? pins.sck_o : tb_sck;
    wire logic   mosi_w = pins.mosi_oe ? pins.mosi_o : tb_mosi;
    wire logic   miso_w = pins.miso_oe ? pins.miso_o : far_miso;
    int          errors = 0, comparisons = 0, cycles = 0, edges = 0, gap = 0, last_gap = 0;
    integer      seed = 32'h0000_f4bf;

    spmp_port spmp_port_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sck_i(sck_w),
        .mosi_i(mosi_w), .miso_i(miso_w), .ss_n_i(ss_n), .pins(pins), .irq(irq));
    spmp_far_slave spmp_far_slave_i (
        .sck(sck_w), .mosi(mosi_w), .sel_n(far_sel_n), .clock_idle_level(far_clock_idle_level),
        .clock_phase_bit(far_clock_phase_bit), .tx_byte(far_tx), .miso(far_miso), .rx_byte(far_rx));

    always #2 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 80000) begin
            errors++;
            wrap_up();
        end
    end
    // Edges are counted on the falling clock, away from the design's updates.
    always @(negedge hclk) begin
        gap++;
        if (sck_w !== sck_q) begin
            edges++;
            last_gap = gap;
            gap = 0;
        end
        sck_q = sck_w;
    end

    // ==========
    // Tasks
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic [9:0] a, input logic wr, input logic [7:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h00_0000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] t;
        ahb(a, 1'b1, d, t);
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        logic [31:0] t;
        ahb(a, 1'b0, 8'h00, t);
        check(t[15:0], {8'h00, exp});
    endtask
    task automatic wait_done(output logic [31:0] s);
        s = 32'h0000_0000;
        for (int n = 0; n < 20000 && s[SPMP_STS_COMPLETE] !== 1'b1; n++)
            ahb(SPMP_ADDR_STATUS, 1'b0, 8'h00, s);
    endtask
    // Plays the far master with phase one: drive on leading edge, sample on trailing.
    task automatic drive_byte(input logic [7:0] m, output logic [7:0] got);
        for (int b = 7; b >= 0; b--) begin
            repeat (60) @(posedge hclk);
            tb_sck <= 1'b1;
            tb_mosi <= m[b];
            repeat (60) @(posedge hclk);
            tb_sck <= 1'b0;
            got[b] = miso_w;
        end
        // The last bit is held past the slave's resynchronised sampling edge.
        repeat (8) @(posedge hclk);
        tb_mosi <= ~m[0];
    endtask
    function automatic int half_of(input int r);
        int div[4] = '{2, 4, 16, 32};
        return SPMP_INT_DIV * div[r] / 2;
    endfunction

    // ==========
    // Main sequence
    initial begin
        logic [31:0] s;
        logic [7:0]  tx, fx, c, got;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(SPMP_ADDR_CONTROL, 8'h04);
        rd_chk(SPMP_ADDR_STATUS, 8'h00);
        wr(10'h03c, 8'hff);
        rd_chk(10'h03c, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c = 8'($random(seed)) & 8'hcf;
            wr(SPMP_ADDR_CONTROL, c);
            rd_chk(SPMP_ADDR_CONTROL, c);
        end
        $display("test registers done");
        wr(SPMP_ADDR_CONTROL, 8'hd4);
        repeat (4) @(posedge hclk);
        check(16'(pins.sck_oe), 16'h0001);
        ss_n <= 1'b0;
        repeat (8) @(posedge hclk);
        ss_n <= 1'b1;
        check(16'(pins.sck_oe), 16'h0000);
        check(16'(irq), 16'h0001);
        // The status read must directly precede the control write that clears the fault.
        rd_chk(SPMP_ADDR_CONTROL, 8'h84);
        rd_chk(SPMP_ADDR_STATUS, 8'h10);
        wr(SPMP_ADDR_CONTROL, 8'h04);
        rd_chk(SPMP_ADDR_STATUS, 8'h00);
        check(16'(irq), 16'h0000);
        $display("test mode fault done");
        for (int i = 0; i < 4; i++) begin
            tx = 8'($random(seed));
            fx = 8'($random(seed));
            far_clock_idle_level <= i[1];
            far_clock_phase_bit <= i[0];
            far_tx <= fx;
            wr(SPMP_ADDR_CONTROL, {4'hd, i[1], i[0], i[1:0]});
            repeat (4) @(posedge hclk);
            check(16'(sck_w), 16'(i[1]));
            far_sel_n <= 1'b0;
            edges = 0;
            wr(SPMP_ADDR_DATA, tx);
            if (i == 3) wr(SPMP_ADDR_DATA, ~tx);
            wait_done(s);
            check(s[15:0], (i == 3) ? 16'h00c0 : 16'h0080);
            check(16'(edges), 16'h0010);
            check(16'(last_gap), 16'(half_of(i)));
            check(16'(irq), 16'h0001);
            check({8'h00, far_rx}, {8'h00, tx});
            rd_chk(SPMP_ADDR_DATA, fx);
            rd_chk(SPMP_ADDR_STATUS, 8'h00);
            far_sel_n <= 1'b1;
        end
        $display("test master transfers done");
        tx = 8'($random(seed));
        fx = 8'($random(seed));
        wr(SPMP_ADDR_CONTROL, 8'h44);
        wr(SPMP_ADDR_DATA, fx);
        check({15'h0000, pins.sck_oe}, 16'h0000);
        ss_n <= 1'b0;
        drive_byte(tx, got);
        check({8'h00, got}, {8'h00, fx});
        wait_done(s);
        check(s[15:0], 16'h0080);
        rd_chk(SPMP_ADDR_DATA, tx);
        ss_n <= 1'b1;
        drive_byte(~tx, got);
        repeat (20) @(posedge hclk);
        rd_chk(SPMP_ADDR_STATUS, 8'h00);
        $display("test slave transfer done");
        wrap_up();
    end
endmodule

bind spmp_port spmp_asserts spmp_asserts_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ss_n_i(ss_n_i), .pins(pins));

`default_nettype wire
